// File: hdl/isp_host_pkg.sv
// Constants, types and register map of the serial programming host.
package isp_host_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0C;
  localparam logic [7:0] OFF_DIV    = 8'h10;

  // Control register fields.
  localparam int CTRL_RST_BIT   = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_WAIT_LSB  = 4;

  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ECHO_BIT = 1;
  localparam int STAT_DONE_BIT = 2;

  // Wait classes selected with a command.
  localparam logic [1:0] WAIT_NONE   = 2'h0;
  localparam logic [1:0] WAIT_PAGE   = 2'h1;
  localparam logic [1:0] WAIT_EEPROM = 2'h2;
  localparam logic [1:0] WAIT_ERASE  = 2'h3;

  // Instruction bytes that the host inspects.
  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] ECHO_BYTE = 8'h53;

  // Clock rate and waits.
  localparam int CLK_HZ          = 25_000_000;
  localparam int STARTUP_WAIT_US = 20_000;
  localparam int PAGE_WAIT_US    = 4_500;
  localparam int EEPROM_WAIT_US  = 9_000;
  localparam int ERASE_WAIT_US   = 9_000;
  localparam int STARTUP_CYC     = (CLK_HZ / 1_000_000) * STARTUP_WAIT_US;
  localparam int PAGE_CYC        = (CLK_HZ / 1_000_000) * PAGE_WAIT_US;
  localparam int EEPROM_CYC      = (CLK_HZ / 1_000_000) * EEPROM_WAIT_US;
  localparam int ERASE_CYC       = (CLK_HZ / 1_000_000) * ERASE_WAIT_US;

  // Reload of the serial clock half-period counter after reset; the half period is this plus one system cycles; at least 3.
  localparam logic [7:0] DIV_RESET = 8'h08;
  localparam logic [7:0] DIV_MIN   = 8'h03;
  // Reset pulse length when resynchronising is this plus one system clocks.
  localparam int RST_PULSE_CYC = 16;

  // Pins driven to the device.
  typedef struct packed {
    logic reset;
    logic sclk;
    logic serialIn;
  } isp_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_WAIT  = 3'b010,
    ST_PULSE = 3'b011,
    ST_SETTLE = 3'b100
  } isp_state_t;

endpackage

// File: hdl/isp_wait_timer.sv
// Down counter that measures the minimum waits of the host.
`timescale 1ns/1ps
`default_nettype none
module isp_wait_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  expired
);

  logic [WIDTH-1:0] remain;

  // Expiry stays high until the next load.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      remain  <= '0;
      expired <= 1'b1;
    end else if (load) begin
      remain  <= count;
      expired <= 1'b0;
    end else if (remain != '0) begin
      remain  <= remain - 1'b1;
      expired <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

endmodule
`default_nettype wire

// File: hdl/isp_host.sv
// Serial in-system programming host with an APB register port.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module isp_host
  import isp_host_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int PAGE_CYCLES    = PAGE_CYC,
  parameter int EEPROM_CYCLES  = EEPROM_CYC,
  parameter int ERASE_CYCLES   = ERASE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             progReset,
  output logic             progClock,
  output logic             progSerialIn,
  input  wire logic        progSerialOut
);

  localparam int TW = 24;

  isp_state_t  state;
  isp_pins_t   pins;
  logic [31:0] txWord;
  logic [31:0] rxWord;
  logic [4:0]  bitCount;
  logic [7:0]  phaseCount;
  logic [7:0]  halfDiv;
  logic [1:0]  waitSel;
  logic        resetActive;
  logic        echoOk;
  logic        cmdDone;
  logic        startPending;
  logic [4:0]  pulseCount;
  logic        sdoMeta;
  logic        sdoSync;

  // Bus decode as named wires.
  wire         busWrite   = psel & penable & pwrite;
  wire         busRead    = psel & ~penable & ~pwrite;
  wire         hitCtrl    = (paddr == OFF_CTRL);
  wire         hitCmd     = (paddr == OFF_CMD);
  wire         hitStatus  = (paddr == OFF_STATUS);
  wire         hitRdata   = (paddr == OFF_RDATA);
  wire         hitDiv     = (paddr == OFF_DIV);
  wire         hitAny     = hitCtrl | hitCmd | hitStatus | hitRdata | hitDiv;
  wire         hostBusy   = (state != ST_IDLE) | startPending;
  wire         startReq   = busWrite & hitCtrl & pwdata[CTRL_START_BIT];
  wire         phaseEnd   = (phaseCount == 8'h00);
  wire         lastBit    = (bitCount == 5'd31);
  wire         timerDone;
  wire [31:0]  statusWord = {29'h0, cmdDone, echoOk, hostBusy};

  // Choose the minimum wait that follows the command just sent.
  function automatic logic [TW-1:0] waitCycles(input logic [1:0] sel);
    unique case (sel)
      WAIT_PAGE:   waitCycles = TW'(PAGE_CYCLES);
      WAIT_EEPROM: waitCycles = TW'(EEPROM_CYCLES);
      WAIT_ERASE:  waitCycles = TW'(ERASE_CYCLES);
      default:     waitCycles = TW'(1);
    endcase
  endfunction

  wire         loadStart = (state == ST_PULSE) && (pulseCount == 5'd0);
  wire         loadWait  = (state == ST_SHIFT) && phaseEnd && pins.sclk && lastBit;
  wire [TW-1:0] timerLoad = loadStart ? TW'(STARTUP_CYCLES) : waitCycles(waitSel);

  // One timer serves both the startup wait and the write waits.
  isp_wait_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (loadStart | loadWait),
    .count   (timerLoad),
    .expired (timerDone)
  );

  // Data-out is a pin from another domain, so it passes two flops.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdoMeta <= 1'b0;
      sdoSync <= 1'b0;
    end else begin
      sdoMeta <= progSerialOut;
      sdoSync <= sdoMeta;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~hitAny;
      if (busRead) begin
        prdata <= hitStatus ? statusWord :
                  hitRdata  ? rxWord :
                  hitCmd    ? txWord :
                  hitDiv    ? {24'h00_0000, halfDiv} :
                  hitCtrl   ? {26'h0, waitSel, 3'b000, resetActive} :
                              32'h0000_0000;
      end
    end
  end

  // Software-held configuration: command word, divider, wait class, reset.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txWord      <= 32'h0000_0000;
      halfDiv     <= DIV_RESET;
      waitSel     <= WAIT_NONE;
      resetActive <= 1'b0;
    end else if (busWrite && !hostBusy) begin
      if (hitCmd) begin
        txWord <= pwdata;
      end
      if (hitDiv) begin
        halfDiv <= (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
      end
      if (hitCtrl) begin
        waitSel     <= pwdata[CTRL_WAIT_LSB +: 2];
        resetActive <= pwdata[CTRL_RST_BIT];
      end
    end
  end

  // Start request is taken only while the host is idle; one written while busy is dropped.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      startPending <= 1'b0;
    end else if (startReq && !hostBusy) begin
      startPending <= 1'b1;
    end else if (state == ST_IDLE) begin
      startPending <= 1'b0;
    end
  end

  // Sequencer: reset pulse, startup wait, four-byte shift, write wait.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      pins       <= '{reset: 1'b0, sclk: 1'b0, serialIn: 1'b0};
      bitCount   <= 5'd0;
      phaseCount <= 8'h00;
      rxWord     <= 32'h0000_0000;
      echoOk     <= 1'b0;
      cmdDone    <= 1'b0;
      pulseCount <= 5'd0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          pins.sclk <= 1'b0;
          if (busWrite && hitCtrl && !hostBusy) begin
            if (pwdata[CTRL_RST_BIT] && !resetActive) begin
              // Entering programming: clock already low, pulse reset high first.
              pins.reset <= 1'b1;
              pulseCount <= 5'(RST_PULSE_CYC);
              state      <= ST_PULSE;
            end else if (!pwdata[CTRL_RST_BIT]) begin
              // Leaving programming: reset released high so the device runs again.
              pins.reset <= 1'b1;
            end
          end
          if (startPending && resetActive) begin
            cmdDone    <= 1'b0;
            bitCount   <= 5'd0;
            phaseCount <= halfDiv;
            pins.serialIn <= txWord[31];
            state      <= ST_SHIFT;
          end
        end
        ST_PULSE: begin
          if (pulseCount != 5'd0) begin
            pulseCount <= pulseCount - 5'd1;
          end else begin
            // Device sits in reset; programming may not begin before the wait.
            pins.reset <= 1'b0;
            state      <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (timerDone) begin
            state <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          if (!phaseEnd) begin
            phaseCount <= phaseCount - 8'h01;
          end else begin
            phaseCount <= halfDiv;
            if (!pins.sclk) begin
              // Rising edge: device samples data-in; data-out settled since fall.
              pins.sclk <= 1'b1;
            end else begin
              pins.sclk <= 1'b0;
              // Sample late in the high phase, clear of the falling edge.
              rxWord <= {rxWord[30:0], sdoSync};
              if (lastBit) begin
                state <= ST_WAIT;
              end else begin
                bitCount      <= bitCount + 5'd1;
                pins.serialIn <= txWord[5'd30 - bitCount];
              end
            end
          end
        end
        ST_WAIT: begin
          // Echo of 0x53 arrives in the third byte slot of the enable opcode.
          if (txWord[31:24] == OP_ENABLE && txWord[23:16] == ECHO_BYTE) begin
            echoOk <= (rxWord[15:8] == ECHO_BYTE);
          end
          // Bus stays closed until the minimum write wait has passed.
          if (timerDone) begin
            cmdDone <= 1'b1;
            state   <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pins come straight from flops.
  assign progReset    = pins.reset;
  assign progClock    = pins.sclk;
  assign progSerialIn = pins.serialIn;

endmodule
`default_nettype wire

// File: verif/isp_host_asserts.sv
// Concurrent checks on the serial pins driven by the programming host.
`timescale 1ns/1ps
`default_nettype none
module isp_host_asserts
  import isp_host_pkg::*;
#(
  parameter int STARTUP_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic progReset,
  input wire logic progClock,
  input wire logic progSerialIn
);
  int lowRun;

  // Cycles since the device reset pin fell; saturates so it never wraps.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) lowRun <= 0;
    else if (progReset) lowRun <= 0;
    else if (lowRun < STARTUP_CYCLES) lowRun <= lowRun + 1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_bit_setup: assert property (
    $rose(progClock) |-> $stable(progSerialIn)) else $error("data moved at clock rise");
  a_bit_hold: assert property (
    progClock && $past(progClock) |-> $stable(progSerialIn)) else $error("data moved while high");
  a_low_phase: assert property (
    $fell(progClock) |-> !progClock [*3]) else $error("clock low phase too short");
  a_high_phase: assert property (
    $rose(progClock) |-> progClock [*3]) else $error("clock high phase too short");
  a_bit_period: assert property (
    $rose(progClock) |-> ##[3:300] $fell(progClock)) else $error("clock stuck high");
  a_pulse_clock: assert property (
    progReset |-> !progClock) else $error("clock moved during reset pulse");
  a_pulse_len: assert property (
    $rose(progReset) |=> progReset) else $error("reset pulse too short");
  a_startup_wait: assert property (
    !progReset && lowRun < STARTUP_CYCLES |-> !progClock) else $error("clock before startup");
endmodule
`default_nettype wire

// File: verif/isp_device_model.sv
// Behavioural model of the device's serial programming port.
`timescale 1ns/1ps
`default_nettype none
module isp_device_model (
  input  wire logic progReset,
  input  wire logic progClock,
  input  wire logic progSerialIn,
  output logic      progSerialOut
);
  logic [7:0]  fuse = 8'hFF;
  logic [7:0]  mem [16];
  logic [7:0]  flash [32];
  logic [7:0]  pbuf [8];
  logic [7:0]  ebuf [4];
  logic [7:0]  ext = 8'h00;
  logic [5:0]  lock = 6'h3F;
  logic [7:0]  sh = 8'h00;
  logic [7:0]  resp;
  logic [31:0] rx = 32'h0000_0000;
  logic [31:0] w;
  logic [4:0]  cnt = 5'd0;
  logic        on = 1'b0;

  // Erased state everywhere; a small slice of each array stands for the whole.
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (flash[i]) flash[i] = 8'hFF;
    foreach (pbuf[i]) pbuf[i] = 8'hFF;
    foreach (ebuf[i]) ebuf[i] = 8'hFF;
  end

  // Fourth slot carries read data; every other slot echoes the last byte.
  always_comb begin
    resp = rx[7:0];
    if (cnt == 5'd24) begin
      casez (rx[23:8])
        16'h5000: resp = fuse;
        16'h5800: resp = {2'b11, lock};
        16'hA0??: resp = mem[rx[3:0]];
        16'hF0??: resp = 8'h00;
        16'b0010_?000_????_????: resp = flash[{ext[0], rx[6], rx[1:0], rx[19]}];
        default: resp = rx[7:0];
      endcase
    end
  end

  // Bits enter MSB first at the rising edge; a high reset pin drops sync.
  always @(posedge progClock or posedge progReset) begin
    if (progReset) begin
      cnt <= 5'd0;
      on <= 1'b0;
    end else begin
      w = {rx[30:0], progSerialIn};
      rx <= w;
      cnt <= cnt + 5'd1;
      if (cnt == 5'd31) begin
        if (w[31:16] == 16'hAC53) on <= 1'b1;
        if (on && w[31:24] == 8'hC0) mem[w[11:8]] <= w[7:0];
        if (on && w[31:16] == 16'hACA0) fuse <= w[7:0];
        if (on && w[31:24] == 8'h4D) ext <= w[15:8];
        if (on && w[31:28] == 4'h4 && w[26:24] == 3'b000) pbuf[{w[9:8], w[27]}] <= w[7:0];
        if (on && w[31:24] == 8'h4C) begin
          for (int k = 0; k < 8; k++) flash[{ext[0], w[14], k[2:0]}] <= pbuf[k];
        end
        if (on && w[31:24] == 8'hC1) ebuf[w[15:14]] <= w[7:0];
        if (on && w[31:24] == 8'hC2) begin
          for (int k = 0; k < 4; k++) mem[{w[11:10], k[1:0]}] <= ebuf[k];
        end
        if (on && w[31:21] == 11'h567) lock <= w[5:0];
        if (on && w[31:21] == 11'h564) begin
          foreach (mem[i]) mem[i] <= 8'hFF;
          foreach (flash[i]) flash[i] <= 8'hFF;
          lock <= 6'h3F;
        end
      end
    end
  end

  // Output moves on the falling edge, so it is steady while the clock is high.
  always @(negedge progClock) begin
    if (cnt[2:0] == 3'd0) sh <= resp;
    else sh <= {sh[6:0], ~sh[7]};
  end

  // With the reset pin high the line is driven with the inverse of the bit, so a stale bit does not pass.
  assign progSerialOut = progReset ? ~sh[7] : sh[7];
endmodule
`default_nettype wire

// File: verif/isp_host_test.sv
// Self-checking testbench of the serial programming host.
`timescale 1ns/1ps
`default_nettype none
module isp_host_test;
  import isp_host_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic        err;
  wire         progReset;
  wire         progClock;
  wire         progSerialIn;
  wire         progSerialOut;
  int          badCount = 0;
  int          checked = 0;

  isp_host #(.STARTUP_CYCLES(200), .PAGE_CYCLES(50), .EEPROM_CYCLES(50),
    .ERASE_CYCLES(50)) dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .progReset(progReset),
    .progClock(progClock), .progSerialIn(progSerialIn), .progSerialOut(progSerialOut));
  isp_device_model device (.progReset(progReset), .progClock(progClock),
    .progSerialIn(progSerialIn), .progSerialOut(progSerialOut));

  always #20 clk_sys = ~clk_sys;

  task automatic giveVerdict();
    if (badCount == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, then an idle cycle so the next setup starts cleanly.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
    if (n >= 50) giveVerdict();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) chk(32'h0000_0000, 32'h0000_0001);
    if (n >= 3000) giveVerdict();
  endtask

  // Send one instruction with a wait class and fetch the word shifted back.
  task automatic cmd(input logic [31:0] w, input logic [1:0] cls);
    apb(1'b1, OFF_CMD, w);
    apb(1'b1, OFF_CTRL, {26'h0, cls, 4'h3});
    waitIdle();
    chk(r & 32'h0000_0004, 32'h0000_0004);
    apb(1'b0, OFF_RDATA, 32'h0000_0000);
  endtask

  // Program page: extended byte, low then high byte, commit, read back.
  task automatic progPageCase();
    cmd(32'h4D00_0100, WAIT_NONE);
    cmd(32'h4000_0133, WAIT_NONE);
    cmd(32'h4800_01C4, WAIT_NONE);
    cmd(32'h4C00_4000, WAIT_PAGE);
    cmd(32'h2000_4100, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_0033);
    cmd(32'h2800_4100, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00C4);
    cmd(32'h4D00_0000, WAIT_NONE);
    cmd(32'h2000_4100, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00FF);
  endtask

  // EEPROM page buffer commit, then lock bits written and read back.
  task automatic pageLockCase();
    cmd(32'hC100_40B7, WAIT_NONE);
    cmd(32'hC200_0800, WAIT_EEPROM);
    cmd(32'hA000_0900, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00B7);
    cmd(32'hACE0_00EA, WAIT_PAGE);
    cmd(32'h5800_0000, WAIT_NONE);
    chk(r & 32'h0000_003F, 32'h0000_002A);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(1'b0, OFF_DIV, 32'h0000_0000);
    chk(r, {24'h0, DIV_RESET});
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    waitIdle();
    cmd(32'hC000_053C, WAIT_EEPROM);
    cmd(32'hAC53_0000, WAIT_NONE);
    chk(r & 32'h0000_FF00, 32'h0000_5300);
    chk(r & 32'h00FF_0000, 32'h00AC_0000);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h0000_0002, 32'h0000_0002);
    cmd(32'hA000_0500, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00FF);
    cmd(32'hC000_03A5, WAIT_EEPROM);
    cmd(32'hA000_0300, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00A5);
    cmd(32'hACA0_005A, WAIT_PAGE);
    cmd(32'h5000_0000, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_005A);
    cmd(32'hF000_0000, WAIT_NONE);
    chk(r & 32'h0000_0001, 32'h0000_0000);
    progPageCase();
    pageLockCase();
    cmd(32'hAC80_0000, WAIT_ERASE);
    cmd(32'hA000_0300, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00FF);
    cmd(32'h4D00_0100, WAIT_NONE);
    cmd(32'h2000_4100, WAIT_NONE);
    chk(r & 32'h0000_00FF, 32'h0000_00FF);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    chk({31'h0, progReset}, 32'h0000_0001);
    giveVerdict();
  end
endmodule

bind isp_host isp_host_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) checks (
  .clk_sys(clk_sys), .nrst(nrst), .progReset(progReset), .progClock(progClock),
  .progSerialIn(progSerialIn));
`default_nettype wire
